// File: verification/buf_ram_model.sv
// Purpose: Buffer RAM and attribute side, summarising each frame
// Assumes: Frame ends at the rising edge of vsync
// Notes: Counts active characters and underline cells
`timescale 1ns/1ps
`default_nettype none
module buf_ram_model (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Display side
    input wire logic vsync,
    input wire logic blank,
    input wire logic address_underline_shared_output,
    input wire logic [13:0] disp_addr,
    input wire logic [13:0] ptr_addr,
    input wire logic ptr_access,
    // Frame summary and last pointer address
    output logic [15:0] act_n,
    output logic [15:0] ul_n,
    output logic [13:0] lo_a,
    output logic [13:0] hi_a,
    output logic [13:0] ptr_seen
);
    logic vs_q;
    logic [15:0] ac;
    logic [15:0] uc;
    logic [13:0] lo;
    logic [13:0] hi;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            {vs_q, ac, uc, hi, act_n, ul_n, lo_a, hi_a, ptr_seen} <= '0;
            lo <= '1;
        end else begin
            vs_q <= vsync;
            if (ptr_access)
                ptr_seen <= ptr_addr;
            if (vsync && !vs_q) begin
                act_n <= ac;
                ul_n <= uc;
                lo_a <= lo;
                hi_a <= hi;
                ac <= '0;
                uc <= '0;
                lo <= '1;
                hi <= '0;
            end else if (!blank) begin
                ac <= ac + 16'h1;
                uc <= uc + 16'(address_underline_shared_output);
                if (disp_addr < lo)
                    lo <= disp_addr;
                if (disp_addr > hi)
                    hi <= disp_addr;
            end
        end
    end
endmodule
`default_nettype wire

// File: verification/crt_display_format_config_tb.sv
// Purpose: Self-checking bench for the display format block
// Assumes: 25 MHz clock, APB with one wait state
// Notes: Frame totals come from the buffer model
`timescale 1ns/1ps
`default_nettype none
module crt_display_format_config_tb;
    import dfc_pkg::*;
    logic core_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic ptr_access_req = 0;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, q;
    logic pready, pslverr, vsync, blank, char_blink, cursor_on, e;
    logic address_underline_shared_output, ptr_access;
    logic [13:0] disp_addr, ptr_addr, lo_a, hi_a, ptr_seen;
    logic [15:0] act_n, ul_n;
    int error_cnt = 0, compares = 0, n, tf, ts, tc1, tc2;
    logic [7:0] rt[3] = '{8'h00, 8'h01, 8'h81};
    logic [7:0] ct[3] = '{8'h02, 8'h03, 8'h03};
    int at[3] = '{48, 128, 128};
    int wt[4] = '{3, 1, 5, 7};
    crt_display_format_config dut (.core_clk, .rst_n, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .ptr_access_req, .vsync, .blank, .disp_addr,
        .address_underline_shared_output, .char_blink, .cursor_on,
        .ptr_addr, .ptr_access);
    buf_ram_model ram (.core_clk, .rst_n, .vsync, .blank,
        .address_underline_shared_output, .disp_addr, .ptr_addr,
        .ptr_access, .act_n, .ul_n, .lo_a, .hi_a, .ptr_seen);
    initial forever #20 core_clk = ~core_clk;
    // ----
    // Tasks
    // ----
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int k = 0;
        @(posedge core_clk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1;
        do begin
            @(posedge core_clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) begin
            error_cnt++;
            $display("MISMATCH t=%0t apb timeout", $time);
        end
        q = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        apb(0, a, 0);
        chk(q, x);
    endtask
    task automatic wait_vs();
        int k = 0;
        while (vsync !== 1'b0 && k < 5000) begin
            @(posedge core_clk);
            k++;
        end
        while (vsync !== 1'b1 && k < 5000) begin
            @(posedge core_clk);
            k++;
        end
    endtask
    task automatic gap(input bit cur, output int t);
        logic v;
        // Skip the rate-switch step and a partial period, then measure
        for (int p = 0; p < 3; p++) begin
            v = cur ? cursor_on : char_blink;
            t = 0;
            while ((cur ? cursor_on : char_blink) === v && t < 40000)
                @(posedge core_clk) t++;
        end
    endtask
    task automatic tally_and_finish();
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // ----
    // Tests
    // ----
    initial begin
        repeat (4) @(posedge core_clk);
        rst_n <= 1;
        rd(OFF_ROWS, 0);
        apb(1, OFF_CPR, 32'hffffff5a);
        rd(OFF_CPR, 32'h5a);
        apb(0, 8'h34, 0);
        chk({31'h0, e}, 1);
        apb(1, 8'h01, 32'h77);
        chk({31'h0, e}, 1);
        $display("registers done");
        apb(1, OFF_PTL, 32'ha5);
        apb(1, OFF_PTH, 32'hff);
        rd(OFF_PTH, 32'hff);
        @(posedge core_clk) ptr_access_req <= 1;
        @(posedge core_clk) ptr_access_req <= 0;
        repeat (3) @(posedge core_clk);
        chk(32'(ptr_seen), 32'h3fa5);
        $display("pointer done");
        apb(1, OFF_FAL, 32'hfe);
        apb(1, OFF_LFH, 32'h03);
        apb(1, OFF_VCU, 32'h25);
        apb(1, OFF_CTRL, 32'h1);
        for (int i = 0; i < 3; i++) begin
            apb(1, OFF_ROWS, 32'(rt[i]));
            apb(1, OFF_CPR, 32'(ct[i]));
            wait_vs();
            wait_vs();
            repeat (2) @(posedge core_clk);
            chk(32'(act_n), at[i]);
            chk(32'(ul_n), at[i] / 16);
            chk(32'(lo_a), 1022);
            chk(32'(hi_a), 1023);
        end
        $display("format done");
        for (int c = 0; c < 4; c++) begin
            apb(1, OFF_VCU, 32'(c * 64 + 8'h25));
            wait_vs();
            wait_vs();
            n = 0;
            while (vsync === 1'b1 && n < 2000)
                @(posedge core_clk) n++;
            chk(n, wt[c] * 12);
        end
        $display("vsync done");
        apb(1, OFF_ROWS, 0);
        apb(1, OFF_CPR, 0);
        gap(0, tf);
        apb(1, OFF_ROWS, 32'h80);
        gap(0, ts);
        chk(ts, 2 * tf);
        chk({31'h0, cursor_on}, 1);
        apb(1, OFF_VCU, 32'h05);
        gap(1, tc1);
        apb(1, OFF_VCU, 32'h15);
        gap(1, tc2);
        chk(tc2, 2 * tc1);
        chk(tf, 2 * tc1);
        $display("blink done");
        tally_and_finish();
    end
    initial begin
        repeat (120000) @(posedge core_clk);
        error_cnt++;
        $display("MISMATCH t=%0t watchdog", $time);
        tally_and_finish();
    end
endmodule
`default_nettype wire

// File: verification/dfc_assertions.sv
// Purpose: Port-level checks for the display format block
// Assumes: One clock, asynchronous active-low reset
// Notes: Bound to the design top
`timescale 1ns/1ps
`default_nettype none
module dfc_assertions (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic pready,
    input wire logic pslverr,
    // Timing and pointer
    input wire logic ptr_access_req,
    input wire logic ptr_access,
    input wire logic vsync,
    input wire logic blank,
    input wire logic char_blink,
    input wire logic [13:0] ptr_addr
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    sequence wait_s;
        psel && penable && !pready;
    endsequence
    one_wait_a: assert property (wait_s |=> pready)
        else $error("ready not after one wait");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    ready_cause_a: assert property (pready |-> $past(psel && penable))
        else $error("ready without access");
    err_ready_a: assert property (pslverr |-> pready && psel)
        else $error("error outside answer");
    ptr_follow_a: assert property (ptr_access == $past(ptr_access_req))
        else $error("pointer access not one cycle after request");
    ptr_hold_a: assert property ($changed(ptr_addr) |->
        $past(psel && penable && pwrite) ||
        $past(psel && penable && pwrite, 2))
        else $error("pointer moved without write");
    vs_blank_a: assert property (vsync |-> blank)
        else $error("vsync outside blanking");
    vs_min_a: assert property ($rose(vsync) |-> vsync[*8])
        else $error("vsync shorter than a line");
    blink_frame_a: assert property ($changed(char_blink) |-> $past(blank))
        else $error("blink phase moved in active video");
endmodule
bind crt_display_format_config dfc_assertions u_chk (.core_clk, .rst_n,
    .psel, .penable, .pwrite, .pready, .pslverr, .ptr_access_req,
    .ptr_access, .vsync, .blank, .char_blink, .ptr_addr);
`default_nettype wire

// File: verilog/blink_div.sv
// Purpose: Frame counter giving character and cursor blink phases
// Assumes: frame_tick pulses once per vertical sync
// Notes:   Counter wraps freely
`timescale 1ns/1ps
`default_nettype none
module blink_div (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Frame event and rate selects
    input wire logic frame_tick,
    input wire logic char_slow,
    input wire logic cursor_slow,
    // Blink phases
    output logic char_phase,
    output logic cursor_phase
);
    logic [6:0] frame_cnt_r;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            frame_cnt_r <= 7'h00;
        end else if (frame_tick) begin
            frame_cnt_r <= frame_cnt_r + 7'h01;
        end
    end

    // Bit n toggles every 2^n frames, period 2^(n+1)
    assign char_phase = char_slow ? frame_cnt_r[6] : frame_cnt_r[5];
    assign cursor_phase = cursor_slow ? frame_cnt_r[5] : frame_cnt_r[4];
endmodule
`default_nettype wire

// File: verilog/buf_addr_gen.sv
// Purpose: Display buffer address with wraparound in programmed area
// Assumes: first address not above last address
// Notes:   Restarts at first address on screen start
`timescale 1ns/1ps
`default_nettype none
module buf_addr_gen (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Control
    input wire logic screen_start,
    input wire logic advance,
    input wire logic [11:0] first_addr,
    input wire logic [3:0] last_code,
    // Address
    output logic [13:0] addr
);
    logic [13:0] addr_r;
    logic [13:0] addr_nxt;
    logic [13:0] last_addr;

    assign last_addr = {last_code, 10'h3ff};
    assign addr_nxt = screen_start ? {2'b00, first_addr} :
        (addr_r == last_addr) ? {2'b00, first_addr} :
        addr_r + 14'h0001;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            addr_r <= 14'h0000;
        end else if (screen_start || advance) begin
            addr_r <= addr_nxt;
        end
    end

    assign addr = addr_r;
endmodule
`default_nettype wire

// File: verilog/crt_display_format_config.sv
// Purpose: Screen format configuration and display address generation
// Assumes: APB slave, 25 MHz character clock, single clock domain
// Notes:   Host programs all fields before setting display enable
//
// The implementer's own choices: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module crt_display_format_config
    import dfc_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Buffer access request from command logic
    input wire logic ptr_access_req,
    // Display timing
    output logic vsync,
    output logic blank,
    output logic [13:0] disp_addr,
    output logic address_underline_shared_output,
    output logic char_blink,
    output logic cursor_on,
    // Pointer-directed buffer access
    output logic [13:0] ptr_addr,
    output logic ptr_access
);
    // -----------------------------------------------------------------
    // Register file
    // -----------------------------------------------------------------
    logic [7:0] cfg_r [NREG];
    logic enable_r;
    logic [3:0] reg_idx;
    logic addr_ok;
    logic is_ctrl;
    logic is_stat;
    logic wr_fire;
    logic rd_fire;
    logic [31:0] rd_mux;
    logic [7:0] status_byte;

    assign reg_idx = paddr[5:2];
    assign addr_ok = (paddr[1:0] == 2'b00) &&
        (reg_idx < 4'(NREG) || paddr == OFF_CTRL || paddr == OFF_STAT);
    assign is_ctrl = (paddr == OFF_CTRL);
    assign is_stat = (paddr == OFF_STAT);
    assign wr_fire = psel && penable && pwrite && !pready;
    assign rd_fire = psel && penable && !pwrite && !pready;

    genvar gi;
    generate
        for (gi = 0; gi < NREG; gi++) begin : g_reg
            logic hit;
            assign hit = wr_fire && addr_ok && (reg_idx == 4'(gi));
            always_ff @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    cfg_r[gi] <= CFG_RESET;
                end else if (hit) begin
                    cfg_r[gi] <= pwdata[7:0];
                end
            end
        end
    endgenerate

    assign rd_mux = !addr_ok ? 32'h0000_0000 :
        is_ctrl ? {31'h0, enable_r} :
        is_stat ? {24'h0, status_byte} :
        {24'h0, cfg_r[reg_idx]};

    // One wait state: pready answers in the second access cycle
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            enable_r <= 1'b0;
        end else begin
            pready <= (wr_fire || rd_fire);
            pslverr <= (wr_fire || rd_fire) && !addr_ok;
            if (rd_fire) begin
                prdata <= rd_mux;
            end
            if (wr_fire && is_ctrl) begin
                enable_r <= pwdata[0];
            end
        end
    end

    // -----------------------------------------------------------------
    // Field decode
    // -----------------------------------------------------------------
    logic [6:0] last_row;
    logic [7:0] last_char;
    logic [1:0] vs_code;
    logic [2:0] vs_width;
    logic [3:0] ul_line;
    logic [11:0] first_addr;
    logic [3:0] last_code;

    // Rows field is seven bits below the blink-rate bit
    assign last_row = cfg_r[0][6:0];
    assign last_char = cfg_r[1];
    assign vs_code = cfg_r[3][7:6];
    assign vs_width = (vs_code == 2'b00) ? VS_W0 :
        (vs_code == 2'b01) ? VS_W1 :
        (vs_code == 2'b10) ? VS_W2 : VS_W3;
    assign ul_line = cfg_r[3][3:0];
    assign first_addr = {cfg_r[5][3:0], cfg_r[4]};
    assign last_code = cfg_r[5][7:4];

    // -----------------------------------------------------------------
    // Raster counters
    // -----------------------------------------------------------------
    logic [7:0] char_cnt_r;
    logic [3:0] line_cnt_r;
    logic [6:0] row_cnt_r;
    logic [3:0] vb_cnt_r;
    logic in_vblank_r;
    logic line_end;
    logic row_end;
    logic screen_end;
    logic frame_end;
    logic h_active;
    logic frame_tick;

    assign line_end = (char_cnt_r == last_char + H_BLANK_CHARS);
    assign row_end = line_end && (line_cnt_r == LINES_PER_ROW);
    assign screen_end = row_end && !in_vblank_r && (row_cnt_r == last_row);
    assign frame_end = line_end && in_vblank_r &&
        (vb_cnt_r == V_BLANK_LINES);
    assign h_active = (char_cnt_r <= last_char);
    assign frame_tick = frame_end;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            char_cnt_r <= 8'h00;
            line_cnt_r <= 4'h0;
            row_cnt_r <= 7'h00;
            vb_cnt_r <= 4'h0;
            in_vblank_r <= 1'b0;
        end else if (!enable_r) begin
            char_cnt_r <= 8'h00;
            line_cnt_r <= 4'h0;
            row_cnt_r <= 7'h00;
            vb_cnt_r <= 4'h0;
            in_vblank_r <= 1'b0;
        end else if (line_end) begin
            char_cnt_r <= 8'h00;
            if (in_vblank_r) begin
                vb_cnt_r <= frame_end ? 4'h0 : vb_cnt_r + 4'h1;
                in_vblank_r <= !frame_end;
            end else begin
                line_cnt_r <= line_cnt_r + 4'h1;
                if (row_end) begin
                    row_cnt_r <= screen_end ? 7'h00 : row_cnt_r + 7'h01;
                    in_vblank_r <= screen_end;
                end
            end
        end else begin
            char_cnt_r <= char_cnt_r + 8'h01;
        end
    end

    // -----------------------------------------------------------------
    // Vertical sync and blanking
    // -----------------------------------------------------------------
    logic [2:0] vs_left_r;
    logic blank_nxt;
    logic blank_fall;

    assign blank_nxt = !enable_r || in_vblank_r || !h_active;
    assign blank_fall = blank && !blank_nxt;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            vs_left_r <= 3'h0;
            vsync <= 1'b0;
            blank <= 1'b1;
        end else begin
            blank <= blank_nxt;
            if (!enable_r) begin
                vs_left_r <= 3'h0;
                vsync <= 1'b0;
            end else if (screen_end) begin
                vs_left_r <= vs_width;
                vsync <= 1'b1;
            end else if (line_end && vs_left_r != 3'h0) begin
                vs_left_r <= vs_left_r - 3'h1;
                vsync <= (vs_left_r != 3'h1);
            end
        end
    end

    // -----------------------------------------------------------------
    // Blink
    // -----------------------------------------------------------------
    logic char_phase;
    logic cursor_phase;

    blink_div u_blink (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .frame_tick(frame_tick),
        .char_slow(cfg_r[0][CHAR_BLINK_BIT]),
        .cursor_slow(cfg_r[3][CURSOR_RATE_BIT]),
        .char_phase(char_phase),
        .cursor_phase(cursor_phase)
    );

    // Blink enable bit: 0 enables blinking, 1 holds the cursor steady
    logic cursor_nxt;
    assign cursor_nxt = cfg_r[3][CURSOR_BLINK_EN_BIT] ? 1'b1 :
        cursor_phase;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            char_blink <= 1'b0;
            cursor_on <= 1'b0;
        end else if (blank) begin
            // Phase changes only while blanked, never during active characters
            char_blink <= char_phase;
            cursor_on <= cursor_nxt;
        end
    end

    // -----------------------------------------------------------------
    // Display address and shared underline output
    // -----------------------------------------------------------------
    logic [13:0] gen_addr;
    logic advance;
    logic scr_start;
    logic ul_hit;
    logic shared_nxt;

    assign advance = enable_r && !in_vblank_r && h_active &&
        (line_cnt_r == LINES_PER_ROW);
    assign scr_start = !enable_r || frame_end;

    buf_addr_gen u_addr (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .screen_start(scr_start),
        .advance(advance),
        .first_addr(first_addr),
        .last_code(last_code),
        .addr(gen_addr)
    );

    assign ul_hit = (line_cnt_r == ul_line);
    // Underline replaces address bit 10 from blank's falling edge on
    assign shared_nxt = blank_fall ? ul_hit :
        blank ? gen_addr[10] : address_underline_shared_output;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            disp_addr <= 14'h0000;
            address_underline_shared_output <= 1'b0;
        end else begin
            disp_addr <= gen_addr;
            address_underline_shared_output <= shared_nxt;
        end
    end

    // -----------------------------------------------------------------
    // Display pointer
    // -----------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ptr_addr <= 14'h0000;
            ptr_access <= 1'b0;
        end else begin
            ptr_addr <= {cfg_r[7][5:0], cfg_r[6]};
            ptr_access <= ptr_access_req;
        end
    end

    assign status_byte = {4'h0, in_vblank_r, vsync, blank, enable_r};
endmodule
`default_nettype wire

// File: verilog/dfc_pkg.sv
// Purpose: Constants shared by the display format configuration block
// Assumes: APB with 32-bit data, word-aligned registers
// Notes:   Offsets are byte addresses of one word per register
package dfc_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_ROWS = 8'h00;
    localparam logic [7:0] OFF_CPR = 8'h04;
    localparam logic [7:0] OFF_CURS = 8'h08;
    localparam logic [7:0] OFF_VCU = 8'h0c;
    localparam logic [7:0] OFF_FAL = 8'h10;
    localparam logic [7:0] OFF_LFH = 8'h14;
    localparam logic [7:0] OFF_PTL = 8'h18;
    localparam logic [7:0] OFF_PTH = 8'h1c;
    localparam logic [7:0] OFF_SPL1 = 8'h20;
    localparam logic [7:0] OFF_SPL2 = 8'h24;
    localparam logic [7:0] OFF_DBL = 8'h28;
    localparam logic [7:0] OFF_CTRL = 8'h2c;
    localparam logic [7:0] OFF_STAT = 8'h30;
    localparam int NREG = 11;
    // Field positions
    localparam int CHAR_BLINK_BIT = 7;
    localparam int CURSOR_BLINK_EN_BIT = 5;
    localparam int CURSOR_RATE_BIT = 4;
    // Reset values of configuration registers
    localparam logic [7:0] CFG_RESET = 8'h00;
    // Vertical sync widths in scan lines, by code
    localparam logic [2:0] VS_W0 = 3'h3;
    localparam logic [2:0] VS_W1 = 3'h1;
    localparam logic [2:0] VS_W2 = 3'h5;
    localparam logic [2:0] VS_W3 = 3'h7;
    // Timing: character clocks per scan line beyond active characters
    localparam logic [7:0] H_BLANK_CHARS = 8'h08;
    localparam logic [3:0] LINES_PER_ROW = 4'hf;
    localparam logic [3:0] V_BLANK_LINES = 4'h8;
endpackage
